// *** logic/bcs_regs.sv ***
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
module bcs_regs
   import bcs_pkg::*;
#(
   parameter logic [7:0] REVISION = REVISION_DEFAULT
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic bridge_error_event,
   output logic serr_msg_send,
   input wire logic frame_valid,
   input wire logic frame_is_io,
   input wire logic [31:0] frame_addr,
   output logic frame_accept,
   output logic frame_abort,
   input wire logic sideband_valid,
   output logic sideband_accept,
   input wire logic [31:0] mem_base,
   input wire logic [31:0] mem_limit,
   input wire logic [31:0] pmem_base,
   input wire logic [31:0] pmem_limit,
   input wire logic [31:0] io_base,
   input wire logic [31:0] io_limit,
   output logic irq
);

   // ==========================================================
   // Declarations
   bcs_phase_t phase;
   bcs_phase_t next_phase;
   logic [11:0] addr_q;
   logic addr_take;
   logic wr_cmd;
   logic wr_sts;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic io_decode_enable;
   logic memory_decode_enable;
   logic bus_master_enable;
   logic system_error_msg_enable;
   logic signaled_system_error;
   logic [15:0] cmd_value;
   logic [15:0] sts_value;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_events;
   logic [IRQ_W-1:0] irq_clear;
   logic [31:0] next_rdata;

   bcs_dec_if dec_if (
      .clk (hclk),
      .rst_n (hresetn)
   );

   // ==========================================================
   // Bus address phase capture
   assign addr_take = hsel && htrans[1] && hready;

   // Word address of the transfer in its data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 12'h000;
      end else if (addr_take) begin
         addr_q <= {haddr[11:2], 2'b00};
      end
   end

   // Data phase sequencing; reads take one wait state
   always_comb begin
      next_phase = PH_IDLE;
      case (phase)
         PH_RDWAIT: begin
            next_phase = PH_RDDATA;
         end
         PH_IDLE, PH_WRITE, PH_RDDATA: begin
            if (addr_take) begin
               next_phase = hwrite ? PH_WRITE : PH_RDWAIT;
            end
         end
         default: begin
            next_phase = PH_IDLE;
         end
      endcase
   end

   // Phase register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= PH_IDLE;
      end else begin
         phase <= next_phase;
      end
   end

   // Handshake and response
   assign hreadyout = (phase != PH_RDWAIT);
   assign hresp = 1'b0; // Always OKAY

   // Write strobes per register
   assign wr_cmd = (phase == PH_WRITE) && (addr_q == ADDR_CMD);
   assign wr_sts = (phase == PH_WRITE) && (addr_q == ADDR_STS);
   assign wr_irq_status = (phase == PH_WRITE) && (addr_q == ADDR_IRQ_STATUS);
   assign wr_irq_mask = (phase == PH_WRITE) && (addr_q == ADDR_IRQ_MASK);

   // ==========================================================
   // Command register, only the four enables are stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_decode_enable <= CMD_RESET[CMD_IO];
         memory_decode_enable <= CMD_RESET[CMD_MEM];
         bus_master_enable <= CMD_RESET[CMD_MASTER];
         system_error_msg_enable <= CMD_RESET[CMD_ERR_MSG];
      end else if (wr_cmd) begin
         io_decode_enable <= hwdata[CMD_IO];
         memory_decode_enable <= hwdata[CMD_MEM];
         bus_master_enable <= hwdata[CMD_MASTER];
         system_error_msg_enable <= hwdata[CMD_ERR_MSG];
      end
   end

   // Command read value; bits 4 and 3 and all others stay fixed
   always_comb begin
      cmd_value = CMD_RESET;
      cmd_value[CMD_IO] = io_decode_enable;
      cmd_value[CMD_MEM] = memory_decode_enable;
      cmd_value[CMD_MASTER] = bus_master_enable;
      cmd_value[CMD_ERR_MSG] = system_error_msg_enable;
   end

   // ==========================================================
   // System error message, sent only while globally enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serr_msg_send <= 1'b0;
      end else begin
         serr_msg_send <= bridge_error_event && system_error_msg_enable;
      end
   end

   // Signaled system error flag; a new message wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         signaled_system_error <= STS_RESET[STS_SYS_ERR];
      end else if (serr_msg_send) begin
         signaled_system_error <= 1'b1;
      end else if (wr_sts && hwdata[STS_SYS_ERR]) begin
         signaled_system_error <= 1'b0;
      end
   end

   // Status read value over hardwired capability bits
   always_comb begin
      sts_value = STS_FIXED;
      sts_value[STS_SYS_ERR] = signaled_system_error;
   end

   // ==========================================================
   // Interrupt status, write one to clear, events win
   assign irq_events = {frame_abort, serr_msg_send};
   assign irq_clear = wr_irq_status ? hwdata[IRQ_W-1:0] : IRQ_RESET;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= IRQ_RESET;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_events;
      end
   end

   // Interrupt mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask <= IRQ_RESET;
      end else if (wr_irq_mask) begin
         irq_mask <= hwdata[IRQ_W-1:0];
      end
   end

   // Level interrupt
   assign irq = |(irq_status & irq_mask);

   // ==========================================================
   // Read data mux; unmapped words read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (addr_q)
         ADDR_CMD: begin
            next_rdata = {16'h0000, cmd_value};
         end
         ADDR_STS: begin
            next_rdata = {16'h0000, sts_value};
         end
         ADDR_REV: begin
            next_rdata = {24'h00_0000, REVISION};
         end
         ADDR_IRQ_STATUS: begin
            next_rdata = {30'h0000_0000, irq_status};
         end
         ADDR_IRQ_MASK: begin
            next_rdata = {30'h0000_0000, irq_mask};
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // Read data register, loaded in the wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (phase == PH_RDWAIT) begin
         hrdata <= next_rdata;
      end
   end

   // ==========================================================
   // Decoder hookup
   assign dec_if.master_en = bus_master_enable;
   assign dec_if.mem_en = memory_decode_enable;
   assign dec_if.io_en = io_decode_enable;
   assign dec_if.frame_valid = frame_valid;
   assign dec_if.frame_is_io = frame_is_io;
   assign dec_if.frame_addr = frame_addr;
   assign dec_if.sideband_valid = sideband_valid;
   assign dec_if.base[RNG_MEM] = mem_base;
   assign dec_if.limit[RNG_MEM] = mem_limit;
   assign dec_if.base[RNG_PMEM] = pmem_base;
   assign dec_if.limit[RNG_PMEM] = pmem_limit;
   assign dec_if.base[RNG_IO] = io_base;
   assign dec_if.limit[RNG_IO] = io_limit;
   assign frame_accept = dec_if.frame_accept;
   assign frame_abort = dec_if.frame_abort;
   assign sideband_accept = dec_if.sideband_accept;

   bcs_range_decode u_dec (
      .dec (dec_if.dec)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_rd_cmd;
      (phase == PH_RDDATA) && (addr_q == ADDR_CMD);
   endsequence

   sequence s_rd_sts;
      (phase == PH_RDDATA) && (addr_q == ADDR_STS);
   endsequence

   property p_wr_inval_zero;
      s_rd_cmd |-> (hrdata[CMD_WR_INVAL] == 1'b0);
   endproperty
   a_wr_inval_zero: assert property (p_wr_inval_zero) else $error("bit 4 of command not zero");

   property p_special_zero;
      s_rd_cmd |-> (hrdata[CMD_SPECIAL] == 1'b0);
   endproperty
   a_special_zero: assert property (p_special_zero) else $error("bit 3 of command not zero");

   // Write data phase, then address phase, wait state and data phase of the read
   property p_cmd_echo;
      (wr_cmd ##1 (!wr_cmd)[*3] ##0 s_rd_cmd)
         |-> (hrdata[15:0] == ($past(hwdata[15:0], 3) & 16'h0107));
   endproperty
   a_cmd_echo: assert property (p_cmd_echo) else $error("command readback wrong");

   property p_parity_zero;
      s_rd_sts |-> (hrdata[15] == 1'b0 && hrdata[8] == 1'b0);
   endproperty
   a_parity_zero: assert property (p_parity_zero) else $error("parity flags set");

   property p_sys_err_set;
      serr_msg_send |=> signaled_system_error;
   endproperty
   a_sys_err_set: assert property (p_sys_err_set) else $error("flag not set by message");

   property p_sys_err_clear;
      (wr_sts && hwdata[STS_SYS_ERR] && !serr_msg_send) |=> !signaled_system_error;
   endproperty
   a_sys_err_clear: assert property (p_sys_err_clear) else $error("write one did not clear");

   property p_sys_err_keep;
      (wr_sts && !hwdata[STS_SYS_ERR] && signaled_system_error) |=> signaled_system_error;
   endproperty
   a_sys_err_keep: assert property (p_sys_err_keep) else $error("write zero cleared flag");

   property p_abort_zero;
      s_rd_sts |-> (hrdata[13:11] == 3'b000);
   endproperty
   a_abort_zero: assert property (p_abort_zero) else $error("abort flags set");

   property p_sel_timing;
      s_rd_sts |-> (hrdata[10:9] == 2'b00);
   endproperty
   a_sel_timing: assert property (p_sel_timing) else $error("select timing not 00");

   property p_back_to_back;
      s_rd_sts |-> hrdata[7];
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("fast back-to-back bit low");

   property p_speed_66;
      s_rd_sts |-> (hrdata[5] && hrdata[6] == 1'b0 && hrdata[4:0] == 5'b00000);
   endproperty
   a_speed_66: assert property (p_speed_66) else $error("66 MHz bit or reserved wrong");

   property p_revision;
      ((phase == PH_RDDATA) && (addr_q == ADDR_REV)) |-> (hrdata == {24'h00_0000, REVISION});
   endproperty
   a_revision: assert property (p_revision) else $error("revision code wrong");

   property p_msg_gate;
      (bridge_error_event && !system_error_msg_enable) |=> !serr_msg_send;
   endproperty
   a_msg_gate: assert property (p_msg_gate) else $error("message sent while disabled");

   property p_msg_send;
      (bridge_error_event && system_error_msg_enable) |=> (serr_msg_send ##1 signaled_system_error);
   endproperty
   a_msg_send: assert property (p_msg_send) else $error("enabled error not reported");

   c_sys_err_cycle: cover property (serr_msg_send ##[1:20] (wr_sts && hwdata[STS_SYS_ERR]));
   c_read_sts: cover property (s_rd_sts);
   c_irq_raise: cover property (!irq ##1 irq);
endmodule : bcs_regs

// *** logic/bcs_pkg.sv ***
// ==========================================================
// Shared constants of the bridge command and status block
package bcs_pkg;
   // ==========================================================
   // Register indices; the byte address is four times the index
   localparam logic [7:0] CMD_INDEX = 8'h04;
   localparam logic [7:0] STS_INDEX = 8'h06;
   localparam logic [7:0] REV_INDEX = 8'h08;
   localparam logic [7:0] IRQ_STATUS_INDEX = 8'h50;
   localparam logic [7:0] IRQ_MASK_INDEX = 8'h51;
   localparam logic [11:0] ADDR_CMD = {2'b00, CMD_INDEX, 2'b00};
   localparam logic [11:0] ADDR_STS = {2'b00, STS_INDEX, 2'b00};
   localparam logic [11:0] ADDR_REV = {2'b00, REV_INDEX, 2'b00};
   localparam logic [11:0] ADDR_IRQ_STATUS = {2'b00, IRQ_STATUS_INDEX, 2'b00};
   localparam logic [11:0] ADDR_IRQ_MASK = {2'b00, IRQ_MASK_INDEX, 2'b00};

   // ==========================================================
   // Command register fields
   localparam int CMD_IO = 0;
   localparam int CMD_MEM = 1;
   localparam int CMD_MASTER = 2;
   localparam int CMD_SPECIAL = 3;
   localparam int CMD_WR_INVAL = 4;
   localparam int CMD_ERR_MSG = 8;
   localparam logic [15:0] CMD_RESET = 16'h0000;

   // ==========================================================
   // Status register fields
   localparam int STS_SYS_ERR = 14;
   localparam logic [15:0] STS_FIXED = 16'h00a0;
   localparam logic [15:0] STS_RESET = 16'h00a0;

   // ==========================================================
   // Revision code, value arbitrary
   localparam logic [7:0] REVISION_DEFAULT = 8'h5a;

   // ==========================================================
   // Interrupt status and mask layout
   localparam int IRQ_SERR = 0;
   localparam int IRQ_ABORT = 1;
   localparam int IRQ_W = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'b00;

   // ==========================================================
   // Decode range slots
   localparam int RNG_MEM = 0;
   localparam int RNG_PMEM = 1;
   localparam int RNG_IO = 2;
   localparam int NUM_RNG = 3;

   // ==========================================================
   // Bus data phase states
   typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_RDWAIT, PH_RDDATA} bcs_phase_t;
endpackage : bcs_pkg

// *** logic/bcs_dec_if.sv ***
`timescale 1ns/100ps
// ==========================================================
// Link between register bank and range decoder
interface bcs_dec_if
   import bcs_pkg::*;
(
   input logic clk,
   input logic rst_n
);
   logic master_en;
   logic mem_en;
   logic io_en;
   logic frame_valid;
   logic frame_is_io;
   logic [31:0] frame_addr;
   logic sideband_valid;
   logic [31:0] base [NUM_RNG];
   logic [31:0] limit [NUM_RNG];
   logic frame_accept;
   logic frame_abort;
   logic sideband_accept;

   modport regs (input clk, input rst_n, output master_en, output mem_en, output io_en,
      output frame_valid, output frame_is_io, output frame_addr, output sideband_valid,
      output base, output limit, input frame_accept, input frame_abort,
      input sideband_accept);
   modport dec (input clk, input rst_n, input master_en, input mem_en, input io_en,
      input frame_valid, input frame_is_io, input frame_addr, input sideband_valid,
      input base, input limit, output frame_accept, output frame_abort,
      output sideband_accept);
endinterface : bcs_dec_if

// *** logic/bcs_range_decode.sv ***
`timescale 1ns/100ps
// ==========================================================
// Secondary master cycle decoder
module bcs_range_decode
   import bcs_pkg::*;
(
   bcs_dec_if.dec dec
);
   logic [NUM_RNG-1:0] hit;
   logic space_hit;

   // ==========================================================
   // One window compare per range slot
   genvar gi;
   generate
      for (gi = 0; gi < NUM_RNG; gi++) begin : g_rng
         assign hit[gi] = (dec.frame_addr >= dec.base[gi]) && (dec.frame_addr <= dec.limit[gi]);
      end
   endgenerate

   // Space gating by the memory and I/O decode enables
   assign space_hit = dec.frame_is_io ? (dec.io_en && hit[RNG_IO])
      : (dec.mem_en && (hit[RNG_MEM] || hit[RNG_PMEM]));

   // Frame cycles need the bus master enable and a hit
   assign dec.frame_accept = dec.frame_valid && dec.master_en && space_hit;
   assign dec.frame_abort = dec.frame_valid && !(dec.master_en && space_hit);
   // Sideband cycles pass whatever the enable
   assign dec.sideband_accept = dec.sideband_valid;

   // ==========================================================
   // Checks
   default clocking cb @(posedge dec.clk); endclocking
   default disable iff (!dec.rst_n);

   property p_master_off;
      (dec.frame_valid && !dec.master_en) |-> (dec.frame_abort && !dec.frame_accept);
   endproperty
   a_master_off: assert property (p_master_off) else $error("frame taken with master off");

   property p_master_hit;
      dec.frame_accept |-> (dec.master_en && (hit != '0) && !dec.frame_abort);
   endproperty
   a_master_hit: assert property (p_master_hit) else $error("frame taken outside a range");

   property p_sideband;
      dec.sideband_valid |-> dec.sideband_accept;
   endproperty
   a_sideband: assert property (p_sideband) else $error("sideband cycle refused");

   property p_mem_gate;
      (dec.frame_accept && !dec.frame_is_io) |-> dec.mem_en;
   endproperty
   a_mem_gate: assert property (p_mem_gate) else $error("memory cycle with decode off");

   property p_io_gate;
      (dec.frame_accept && dec.frame_is_io) |-> (dec.io_en && hit[RNG_IO]);
   endproperty
   a_io_gate: assert property (p_io_gate) else $error("I/O cycle with decode off");

   c_frame_taken: cover property (dec.frame_accept);
   c_frame_abort: cover property (dec.frame_abort && dec.master_en);
endmodule : bcs_range_decode

// *** tb/bcs_sec_master.sv ***
`timescale 1ns/100ps
// ==========================================================
// Secondary bus master and error source facing the bridge
module bcs_sec_master
#(
   parameter logic [31:0] MEM_BOT = 32'h1000_0000,
   parameter logic [31:0] MEM_TOP = 32'h1000_ffff,
   parameter logic [31:0] PMEM_BOT = 32'h2000_0000,
   parameter logic [31:0] PMEM_TOP = 32'h2000_ffff,
   parameter logic [31:0] IO_BOT = 32'h0000_1000,
   parameter logic [31:0] IO_TOP = 32'h0000_1fff
)
(
   input wire logic hclk,
   input wire logic frame_accept,
   input wire logic frame_abort,
   input wire logic sideband_accept,
   input wire logic serr_msg_send,
   output logic frame_valid,
   output logic frame_is_io,
   output logic [31:0] frame_addr,
   output logic sideband_valid,
   output logic bridge_error_event,
   output logic [31:0] mem_base,
   output logic [31:0] mem_limit,
   output logic [31:0] pmem_base,
   output logic [31:0] pmem_limit,
   output logic [31:0] io_base,
   output logic [31:0] io_limit
);
   // Decode windows as programmed by the bridge base and limit registers
   assign mem_base = MEM_BOT;
   assign mem_limit = MEM_TOP;
   assign pmem_base = PMEM_BOT;
   assign pmem_limit = PMEM_TOP;
   assign io_base = IO_BOT;
   assign io_limit = IO_TOP;

   // Idle bus at time zero
   initial begin
      frame_valid = 1'b0;
      frame_is_io = 1'b0;
      frame_addr = 32'h0000_0000;
      sideband_valid = 1'b0;
      bridge_error_event = 1'b0;
   end

   // One frame cycle with a sideband request beside it; address scrambled once released
   task automatic cycle(input logic io, input logic [31:0] addr, output logic [2:0] res);
      @(posedge hclk);
      frame_valid <= 1'b1;
      frame_is_io <= io;
      frame_addr <= addr;
      sideband_valid <= 1'b1;
      @(posedge hclk);
      res = {sideband_accept, frame_abort, frame_accept};
      frame_valid <= 1'b0;
      sideband_valid <= 1'b0;
      frame_addr <= ~addr;
   endtask : cycle

   // One cycle of an error condition; message output sampled at the two edges after
   task automatic err_pulse(output logic [1:0] seen);
      @(posedge hclk);
      bridge_error_event <= 1'b1;
      @(posedge hclk);
      bridge_error_event <= 1'b0;
      @(posedge hclk);
      seen[0] = serr_msg_send;
      @(posedge hclk);
      seen[1] = serr_msg_send;
   endtask : err_pulse
endmodule : bcs_sec_master

// *** tb/tb_bcs_regs.sv ***
`timescale 1ns/100ps
// ==========================================================
// Bench for the bridge command and status registers
module tb_bcs_regs
   import bcs_pkg::*;
();
   localparam logic [7:0] REV = 8'h3c; // Revision code for this run, arbitrary
   logic hclk, hresetn, hsel, hwrite, hready, hresp, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic fv, fio, fsb, fev, facc, fabt, fsba, serr;
   logic [31:0] fadr, mb, ml, pb, pl, ib, il;
   logic [2:0] res;
   logic [1:0] pulse;
   int num_errors = 0;
   int samples_checked = 0;
   logic [31:0] adr_tab [5] = '{32'h1000_0000, 32'h2000_ffff, 32'h1001_0000, 32'h0000_1fff,
      32'h0000_0fff};
   logic io_tab [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   logic hit_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

   // ==========================================================
   // Clock and design under test
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   bcs_regs #(.REVISION(REV)) i_bcs_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .bridge_error_event(fev), .serr_msg_send(serr), .frame_valid(fv), .frame_is_io(fio),
      .frame_addr(fadr), .frame_accept(facc), .frame_abort(fabt), .sideband_valid(fsb),
      .sideband_accept(fsba), .mem_base(mb), .mem_limit(ml), .pmem_base(pb),
      .pmem_limit(pl), .io_base(ib), .io_limit(il), .irq(irq));

   bcs_sec_master i_bcs_sec_master (.hclk(hclk), .frame_accept(facc), .frame_abort(fabt),
      .sideband_accept(fsba), .serr_msg_send(serr), .frame_valid(fv), .frame_is_io(fio),
      .frame_addr(fadr), .sideband_valid(fsb), .bridge_error_event(fev), .mem_base(mb),
      .mem_limit(ml), .pmem_base(pb), .pmem_limit(pl), .io_base(ib), .io_limit(il));

   // ==========================================================
   // Verdict and comparison
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
         num_errors++;
      end
   endtask : check

   // ==========================================================
   // Bus master tasks
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            num_errors++;
            conclude();
         end
         @(posedge hclk);
      end
   endtask : wait_ready

   task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
      check(hresp, 1'b0);
   endtask : access

   // Interrupt level one edge after the write that changes it
   task automatic irq_chk(input logic exp);
      @(posedge hclk);
      check(irq, exp);
   endtask : irq_chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      access(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      access(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rd_chk

   // ==========================================================
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values and hardwired fields
      rd_chk(ADDR_CMD, 32'h0000_0000);
      rd_chk(ADDR_STS, 32'h0000_00a0);
      rd_chk(ADDR_REV, {24'h00_0000, REV});
      rd_chk(ADDR_IRQ_MASK, 32'h0000_0000);
      // Writes to fixed and reserved bits are dropped
      wr(ADDR_CMD, 32'hffff_ffff);
      rd_chk(ADDR_CMD, 32'h0000_0107);
      wr(ADDR_STS, 32'hffff_bfff);
      rd_chk(ADDR_STS, 32'h0000_00a0);
      wr(ADDR_REV, 32'hffff_ffff);
      rd_chk(ADDR_REV, {24'h00_0000, REV});
      wr(12'hffc, 32'hffff_ffff);
      rd_chk(12'hffc, 32'h0000_0000);
      // Decode of frame cycles for every combination of the three enables
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_CMD, c);
         for (int k = 0; k < 5; k++) begin
            i_bcs_sec_master.cycle(io_tab[k], adr_tab[k], res);
            check(res, {1'b1, ~(c[2] & hit_tab[k] & (io_tab[k] ? c[0] : c[1])),
               c[2] & hit_tab[k] & (io_tab[k] ? c[0] : c[1])});
         end
      end
      // Abort events raise the interrupt only when unmasked
      rd_chk(ADDR_IRQ_STATUS, 32'h0000_0002);
      check(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 32'h0000_0002);
      irq_chk(1'b1);
      wr(ADDR_IRQ_STATUS, 32'h0000_0002);
      irq_chk(1'b0);
      rd_chk(ADDR_IRQ_STATUS, 32'h0000_0000);
      // No message while the global enable is off
      wr(ADDR_CMD, 32'h0000_0007);
      i_bcs_sec_master.err_pulse(pulse);
      check(pulse, 2'b00);
      rd_chk(ADDR_STS, 32'h0000_00a0);
      // Message sent, flag set, cleared only by a one
      wr(ADDR_CMD, 32'h0000_0100);
      wr(ADDR_IRQ_MASK, 32'h0000_0001);
      i_bcs_sec_master.err_pulse(pulse);
      check(pulse, 2'b01);
      rd_chk(ADDR_STS, 32'h0000_40a0);
      check(irq, 1'b1);
      wr(ADDR_STS, 32'h0000_0000);
      rd_chk(ADDR_STS, 32'h0000_40a0);
      wr(ADDR_STS, 32'h0000_4000);
      rd_chk(ADDR_STS, 32'h0000_00a0);
      wr(ADDR_IRQ_STATUS, 32'h0000_0001);
      irq_chk(1'b0);
      // Reset in mid-run returns the enables to zero
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(ADDR_CMD, 32'h0000_0000);
      conclude();
   end
endmodule : tb_bcs_regs
